// *** osc_switch_pkg.sv ***
// package for the oscillator switch control block
// assumes a single clk domain and a plain strobe register port
package osc_switch_pkg;

  // ==========================================================
  // register offsets (word index on the plain port)
  localparam logic [1:0] ADDR_OSC_CONTROL  = 2'h0;
  localparam logic [1:0] ADDR_CLOCK_DIV    = 2'h1;
  localparam logic [1:0] ADDR_FAST_RC_TUNE = 2'h2;

  // ==========================================================
  // oscillator_control field positions
  localparam int POS_CUR_SRC   = 12;
  localparam int POS_NEXT_SRC  = 8;
  localparam int POS_SEL_LOCK  = 7;
  localparam int POS_PIN_LOCK  = 6;
  localparam int POS_PLL_OK    = 5;
  localparam int POS_CLK_FAIL  = 3;
  localparam int POS_PRI_KEEP  = 2;
  localparam int POS_SEC_EN    = 1;
  localparam int POS_SWITCH    = 0;
  // clock_divider field positions
  localparam int POS_RECOVER   = 15;
  localparam int POS_RATIO     = 12;
  localparam int POS_SLOW_EN   = 11;
  localparam int POS_POSTSCALE = 8;

  // ==========================================================
  // reset values
  localparam logic [2:0] RST_RATIO     = 3'h3;
  localparam logic [2:0] RST_POSTSCALE = 3'h1;
  localparam logic [5:0] RST_TRIM      = 6'h00;

  // ==========================================================
  // unlock keys
  localparam logic [7:0] KEY_HI_1 = 8'h78;
  localparam logic [7:0] KEY_HI_2 = 8'h9a;
  localparam logic [7:0] KEY_LO_1 = 8'h46;
  localparam logic [7:0] KEY_LO_2 = 8'h57;

  // ==========================================================
  // source encodings
  localparam logic [2:0] SRC_FAST_RC  = 3'h0;
  localparam logic [2:0] SRC_FRC_MULT = 3'h1;
  localparam logic [2:0] SRC_PRIMARY  = 3'h2;
  localparam logic [2:0] SRC_PRI_MULT = 3'h3;
  localparam logic [2:0] SRC_SECOND   = 3'h4;
  localparam logic [2:0] SRC_LOW_RC   = 3'h5;
  localparam logic [2:0] SRC_RESERVED = 3'h6;
  localparam logic [2:0] SRC_FRC_DIV  = 3'h7;

  // ==========================================================
  // timing: settle cycles of new clock
  localparam int SETTLE_CYCLES = 10;

  // register request bundle
  typedef struct packed {
    logic [1:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_type;

  // oscillator enables
  typedef struct packed {
    logic primary;
    logic secondary;
    logic fast_rc;
    logic low_rc;
    logic multiplier;
  } osc_en_type;

endpackage

// *** osc_switch_ctrl.sv ***
// oscillator switch control: registers, unlock keys, switch sequence
// assumes ready pulses from oscillators arrive as async pins
//
// What this block does
// - read-only current source field with eight documented encodings
// - writable next source field, reset from boot source configuration
// - set-only selection lock blocks switches while monitor is on
// - pin map lock changes only after unlock; one-shot blocks clearing
// - pll settled flag set on lock, cleared on switch or non-pll mode
// - clock fail flag set by monitor, software may only clear
// - primary sleep keep holds primary running during sleep
// - secondary oscillator enable bit runs the 32 kHz oscillator
// - switch request bit starts switch and stays high until done
// - slowdown enable applies ratio, cleared on interrupt when recovering
// - switching disabled: boot source shown, request held at zero
// - keys 78h then 9ah unlock one next source write
// - keys 46h then 57h unlock one switch request set
// - equal current and next sources abort switch, clear request
// - valid switch start clears pll settled and clock fail flags
// - power target, wait crystal timer or pll lock
// - count ten new clock cycles before handover
// - on completion clear request and copy next into current
// - stop old source except low rc with watchdog or monitor on, or enabled secondary
// - switching needs cfg upper bit zero; monitor needs both zero
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ns

module osc_switch_ctrl #(
  parameter int SETTLE = osc_switch_pkg::SETTLE_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire osc_switch_pkg::reg_req_type req,
  output logic [15:0]                     rdata,
  input  wire logic [2:0]                 boot_source_cfg,
  input  wire logic [1:0]                 switch_monitor_cfg,
  input  wire logic                       pin_map_one_shot,
  input  wire logic                       watchdog_enable,
  input  wire logic                       crystal_startup_done,
  input  wire logic                       pll_locked,
  input  wire logic                       new_clock_tick,
  input  wire logic                       fail_detect,
  input  wire logic                       sleep_mode,
  input  wire logic                       interrupt_event,
  output osc_switch_pkg::osc_en_type      osc_enable,
  output logic [2:0]                      system_source,
  output logic                            slowdown_active,
  output logic [2:0]                      slowdown_ratio,
  output logic [2:0]                      fast_rc_postscale,
  output logic [5:0]                      fast_rc_trim,
  output logic                            pin_map_lock
);

  initial begin
    if (SETTLE < 1 || SETTLE > 255) begin
      $error("settle count out of range");
    end
  end

  // ==========================================================
  // pin synchronisers
  logic [1:0] sync_xtal;
  logic [1:0] sync_pll;
  logic [1:0] sync_tick;
  logic [1:0] sync_fail;
  logic       tick_last;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_xtal <= 2'h0;
      sync_pll  <= 2'h0;
      sync_tick <= 2'h0;
      sync_fail <= 2'h0;
      tick_last <= 1'b0;
    end else begin
      sync_xtal <= {sync_xtal[0], crystal_startup_done};
      sync_pll  <= {sync_pll[0], pll_locked};
      sync_tick <= {sync_tick[0], new_clock_tick};
      sync_fail <= {sync_fail[0], fail_detect};
      tick_last <= sync_tick[1];
    end
  end
  logic tick_edge;
  assign tick_edge = sync_tick[1] & ~tick_last;

  // ==========================================================
  // configuration decode
  logic switch_allowed;
  logic monitor_on;
  assign switch_allowed = ~switch_monitor_cfg[1];
  assign monitor_on     = (switch_monitor_cfg == 2'h0);

  // ==========================================================
  // unlock state machine
  typedef enum logic [4:0] {
    UL_IDLE  = 5'b00001,
    UL_HI_1  = 5'b00010,
    UL_HI_OK = 5'b00100,
    UL_LO_1  = 5'b01000,
    UL_LO_OK = 5'b10000
  } unlock_type;
  unlock_type unlock;

  logic wr_ctl;
  logic [7:0] wr_hi;
  logic [7:0] wr_lo;
  assign wr_ctl = req.wr & (req.addr == osc_switch_pkg::ADDR_OSC_CONTROL);
  assign wr_hi  = req.wdata[15:8];
  assign wr_lo  = req.wdata[7:0];

  logic hi_open;
  logic lo_open;
  assign hi_open = wr_ctl & (unlock == UL_HI_OK);
  assign lo_open = wr_ctl & (unlock == UL_LO_OK);

  // keys must arrive on consecutive accesses
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unlock <= UL_IDLE;
    end else if (req.wr | req.rd) begin
      unlock <= UL_IDLE;
      if (wr_ctl) begin
        unique case (unlock)
          UL_IDLE: begin
            if (wr_hi == osc_switch_pkg::KEY_HI_1) begin
              unlock <= UL_HI_1;
            end else if (wr_lo == osc_switch_pkg::KEY_LO_1) begin
              unlock <= UL_LO_1;
            end
          end
          UL_HI_1: begin
            if (wr_hi == osc_switch_pkg::KEY_HI_2) begin
              unlock <= UL_HI_OK;
            end
          end
          UL_LO_1: begin
            if (wr_lo == osc_switch_pkg::KEY_LO_2) begin
              unlock <= UL_LO_OK;
            end
          end
          UL_HI_OK, UL_LO_OK: begin
            unlock <= UL_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // switch sequencer
  typedef enum logic [4:0] {
    SW_IDLE   = 5'b00001,
    SW_CHECK  = 5'b00010,
    SW_START  = 5'b00100,
    SW_SETTLE = 5'b01000,
    SW_DONE   = 5'b10000
  } switch_type;
  switch_type sw_state;

  logic [2:0] current_source_sel;
  logic [2:0] next_source_sel;
  logic       switch_request;
  logic       selection_lock;
  logic       pll_settled;
  logic       clock_fail_flag;
  logic       primary_sleep_keep;
  logic       secondary_osc_enable;
  logic [7:0] settle_count;
  logic [2:0] old_source;
  logic       boot_seen;

  function automatic logic uses_mult(input logic [2:0] s);
    uses_mult = (s == osc_switch_pkg::SRC_FRC_MULT) |
                (s == osc_switch_pkg::SRC_PRI_MULT);
  endfunction

  function automatic logic uses_crystal(input logic [2:0] s);
    uses_crystal = (s == osc_switch_pkg::SRC_PRIMARY) |
                   (s == osc_switch_pkg::SRC_PRI_MULT) |
                   (s == osc_switch_pkg::SRC_SECOND);
  endfunction

  logic locked_sel;
  assign locked_sel = selection_lock & monitor_on;

  logic target_ready;
  assign target_ready = (~uses_crystal(next_source_sel) | sync_xtal[1]) &
                        (~uses_mult(next_source_sel) | pll_settled);

  // request set via unlocked low byte write
  logic request_set;
  assign request_set = lo_open & wr_lo[osc_switch_pkg::POS_SWITCH] &
                       switch_allowed & ~locked_sel;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sw_state       <= SW_IDLE;
      switch_request <= 1'b0;
      settle_count   <= 8'h00;
      old_source     <= 3'h0;
    end else if (!switch_allowed) begin
      sw_state       <= SW_IDLE;
      switch_request <= 1'b0;
    end else begin
      unique case (sw_state)
        SW_IDLE: begin
          if (request_set) begin
            switch_request <= 1'b1;
            sw_state       <= SW_CHECK;
          end
        end
        SW_CHECK: begin
          if (current_source_sel == next_source_sel) begin
            switch_request <= 1'b0;
            sw_state       <= SW_IDLE;
          end else begin
            old_source <= current_source_sel;
            sw_state   <= SW_START;
          end
        end
        SW_START: begin
          settle_count <= 8'h00;
          if (target_ready) begin
            sw_state <= SW_SETTLE;
          end
        end
        SW_SETTLE: begin
          if (tick_edge) begin
            settle_count <= settle_count + 8'h01;
            if (settle_count == 8'(SETTLE - 1)) begin
              sw_state <= SW_DONE;
            end
          end
        end
        SW_DONE: begin
          switch_request <= 1'b0;
          sw_state       <= SW_IDLE;
        end
      endcase
    end
  end

  // current source: boot value, then copy on completion
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      current_source_sel <= osc_switch_pkg::SRC_FAST_RC;
      boot_seen          <= 1'b0;
    end else if (!boot_seen || !switch_allowed) begin
      current_source_sel <= boot_source_cfg;
      boot_seen          <= 1'b1;
    end else if (sw_state == SW_DONE) begin
      current_source_sel <= next_source_sel;
    end
  end

  // next source: boot value, then keyed writes
  logic next_seen;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      next_source_sel <= osc_switch_pkg::SRC_FAST_RC;
      next_seen       <= 1'b0;
    end else if (!next_seen) begin
      next_source_sel <= boot_source_cfg;
      next_seen       <= 1'b1;
    end else if (hi_open && !locked_sel && sw_state == SW_IDLE &&
                 wr_hi[2:0] != osc_switch_pkg::SRC_RESERVED) begin
      next_source_sel <= wr_hi[2:0];
    end
  end

  // low byte control bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      selection_lock       <= 1'b0;
      pin_map_lock         <= 1'b0;
      primary_sleep_keep   <= 1'b0;
      secondary_osc_enable <= 1'b0;
    end else if (lo_open) begin
      if (wr_lo[osc_switch_pkg::POS_SEL_LOCK]) begin
        selection_lock <= 1'b1;
      end
      if (!(pin_map_one_shot && pin_map_lock)) begin
        pin_map_lock <= wr_lo[osc_switch_pkg::POS_PIN_LOCK];
      end
      primary_sleep_keep   <= wr_lo[osc_switch_pkg::POS_PRI_KEEP];
      secondary_osc_enable <= wr_lo[osc_switch_pkg::POS_SEC_EN];
    end
  end

  // pll settled and clock fail flags
  logic clear_fail;
  assign clear_fail = lo_open & ~wr_lo[osc_switch_pkg::POS_CLK_FAIL];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pll_settled     <= 1'b0;
      clock_fail_flag <= 1'b0;
    end else begin
      if ((sw_state == SW_CHECK &&
           current_source_sel != next_source_sel) ||
          (!uses_mult(current_source_sel) &&
           !uses_mult(next_source_sel))) begin
        pll_settled <= 1'b0;
      end else begin
        pll_settled <= sync_pll[1];
      end
      if (monitor_on && sync_fail[1]) begin
        clock_fail_flag <= 1'b1;
      end else if ((sw_state == SW_CHECK &&
                    current_source_sel != next_source_sel) ||
                   clear_fail) begin
        clock_fail_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // divider and trim registers
  logic recover_on_interrupt;
  logic core_slowdown_enable;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      recover_on_interrupt <= 1'b0;
      slowdown_ratio       <= osc_switch_pkg::RST_RATIO;
      core_slowdown_enable <= 1'b0;
      fast_rc_postscale    <= osc_switch_pkg::RST_POSTSCALE;
    end else begin
      if (req.wr && req.addr == osc_switch_pkg::ADDR_CLOCK_DIV) begin
        recover_on_interrupt <= req.wdata[osc_switch_pkg::POS_RECOVER];
        slowdown_ratio       <= req.wdata[14:12];
        core_slowdown_enable <= req.wdata[osc_switch_pkg::POS_SLOW_EN];
        fast_rc_postscale    <= req.wdata[10:8];
      end
      if (interrupt_event && recover_on_interrupt) begin
        core_slowdown_enable <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fast_rc_trim <= osc_switch_pkg::RST_TRIM;
    end else if (req.wr &&
                 req.addr == osc_switch_pkg::ADDR_FAST_RC_TUNE) begin
      fast_rc_trim <= req.wdata[5:0];
    end
  end

  // ==========================================================
  // oscillator enables and system source
  function automatic logic src_is(input logic [2:0] s, input int kind);
    unique case (kind)
      0: src_is = uses_crystal(s) & (s != osc_switch_pkg::SRC_SECOND);
      1: src_is = (s == osc_switch_pkg::SRC_SECOND);
      2: src_is = (s == osc_switch_pkg::SRC_FAST_RC) |
                  (s == osc_switch_pkg::SRC_FRC_MULT) |
                  (s == osc_switch_pkg::SRC_FRC_DIV);
      default: src_is = (s == osc_switch_pkg::SRC_LOW_RC);
    endcase
  endfunction

  logic busy;
  assign busy = (sw_state == SW_START) | (sw_state == SW_SETTLE);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_enable      <= '0;
      system_source   <= osc_switch_pkg::SRC_FAST_RC;
      slowdown_active <= 1'b0;
    end else begin
      // old source drops once current_source_sel changes
      osc_enable.primary <= (src_is(current_source_sel, 0) |
                             (busy & src_is(next_source_sel, 0))) &
                            (~sleep_mode | primary_sleep_keep);
      osc_enable.secondary <= secondary_osc_enable |
                              src_is(current_source_sel, 1) |
                              (busy & src_is(next_source_sel, 1));
      osc_enable.fast_rc <= src_is(current_source_sel, 2) |
                            (busy & src_is(next_source_sel, 2));
      osc_enable.low_rc <= src_is(current_source_sel, 3) |
                           (busy & src_is(next_source_sel, 3)) |
                           watchdog_enable | monitor_on;
      osc_enable.multiplier <= uses_mult(current_source_sel) |
                               (busy & uses_mult(next_source_sel));
      system_source   <= current_source_sel;
      slowdown_active <= core_slowdown_enable;
    end
  end

  // ==========================================================
  // read data, one cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else if (req.rd) begin
      unique case (req.addr)
        osc_switch_pkg::ADDR_OSC_CONTROL:
          rdata <= {1'b0, current_source_sel, 1'b0, next_source_sel,
                    selection_lock, pin_map_lock, pll_settled, 1'b0,
                    clock_fail_flag, primary_sleep_keep,
                    secondary_osc_enable, switch_request};
        osc_switch_pkg::ADDR_CLOCK_DIV:
          rdata <= {recover_on_interrupt, slowdown_ratio,
                    core_slowdown_enable, fast_rc_postscale, 8'h00};
        osc_switch_pkg::ADDR_FAST_RC_TUNE:
          rdata <= {10'h000, fast_rc_trim};
        default:
          rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule

// *** osc_switch_checker.sv ***
// checker: port timing of the oscillator switch control block
// assumes it is bound onto osc_switch_ctrl in one clk domain
`timescale 1ns/1ns

module osc_switch_checker (
  input wire logic                        clk,
  input wire logic                        rstn,
  input wire osc_switch_pkg::reg_req_type req,
  input wire logic [15:0]                 rdata,
  input wire logic [2:0]                  boot_source_cfg,
  input wire logic [1:0]                  switch_monitor_cfg,
  input wire logic                        pin_map_one_shot,
  input wire logic                        pll_locked,
  input wire logic                        interrupt_event,
  input wire logic                        slowdown_active,
  input wire logic [2:0]                  slowdown_ratio,
  input wire logic [5:0]                  fast_rc_trim,
  input wire logic                        pin_map_lock
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic recover;

  // ==========================================================
  // helper: recover bit as last written
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      recover <= 1'b0;
    end else if (req.wr && req.addr == 2'h1) begin
      recover <= req.wdata[15];
    end
  end

  // ==========================================================
  // assertions
  a_req_held_off: assert property (
    switch_monitor_cfg[1] && req.rd && req.addr == 2'h0 |=> !rdata[0])
    else $error("request bit seen while switching is off");
  a_boot_shown: assert property (
    switch_monitor_cfg[1] && req.rd && req.addr == 2'h0
    |=> rdata[14:12] == $past(boot_source_cfg))
    else $error("current source differs from boot source");
  a_trim_write: assert property (
    req.wr && req.addr == 2'h2 |=> fast_rc_trim == $past(req.wdata[5:0]))
    else $error("trim output not updated by write");
  a_ratio_write: assert property (
    req.wr && req.addr == 2'h1
    |=> slowdown_ratio == $past(req.wdata[14:12]))
    else $error("ratio output not updated by write");
  a_slow_recover: assert property (
    interrupt_event && recover && !(req.wr && req.addr == 2'h1)
    |-> ##[1:2] !slowdown_active)
    else $error("slowdown kept after interrupt");
  a_lock_one_shot: assert property (
    pin_map_one_shot && pin_map_lock |=> pin_map_lock)
    else $error("pin map lock cleared under one-shot");
  a_pll_flag_low: assert property (
    (!pll_locked)[*5] ##0 (req.rd && req.addr == 2'h0) |=> !rdata[5])
    else $error("pll settled flag high without lock");
  a_unmapped_zero: assert property (
    req.rd && req.addr == 2'h3 |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule

bind osc_switch_ctrl osc_switch_checker u_chk (
  .clk, .rstn, .req, .rdata, .boot_source_cfg, .switch_monitor_cfg,
  .pin_map_one_shot, .pll_locked, .interrupt_event, .slowdown_active,
  .slowdown_ratio, .fast_rc_trim, .pin_map_lock
);

// *** tb.sv ***
// testbench: register traffic and clock switch sequences
// assumes osc_switch_ctrl built with a shortened settle count
`timescale 1ns/1ns

module tb;
  localparam logic [1:0] CTL = osc_switch_pkg::ADDR_OSC_CONTROL;
  localparam logic [1:0] DIV = osc_switch_pkg::ADDR_CLOCK_DIV;
  localparam logic [1:0] FAST_RC_TRIM = osc_switch_pkg::ADDR_FAST_RC_TUNE;
  logic                        clk = 1'b0;
  logic                        rstn = 1'b0;
  osc_switch_pkg::reg_req_type req = '0;
  logic [15:0]                 rdata;
  logic [2:0]                  boot = 3'h0;
  logic [1:0]                  cfg = 2'h0;
  logic                        xtal = 1'b0;
  logic                        tick = 1'b0;
  logic                        fail = 1'b0;
  logic                        sleep = 1'b0;
  logic                        irq = 1'b0;
  osc_switch_pkg::osc_en_type  osc_en;
  logic [2:0]                  sys_src;
  logic                        slow;
  logic                        pin_lock;
  logic [2:0]                  ratio;
  logic [2:0]                  post;
  logic [5:0]                  trim;
  logic                        rd_d = 1'b0;
  logic [31:0]                 exp_q[$];
  logic [31:0]                 note;
  int                          n_mismatch = 0;
  int                          check_count = 0;

  // clock, 4 ns period
  always #2 clk = ~clk;

  osc_switch_ctrl #(.SETTLE(2)) DUT (
    .clk                  (clk),
    .rstn                 (rstn),
    .req                  (req),
    .rdata                (rdata),
    .boot_source_cfg      (boot),
    .switch_monitor_cfg   (cfg),
    .pin_map_one_shot     (1'b1),
    .watchdog_enable      (1'b0),
    .crystal_startup_done (xtal),
    .pll_locked           (1'b0),
    .new_clock_tick       (tick),
    .fail_detect          (fail),
    .sleep_mode           (sleep),
    .interrupt_event      (irq),
    .osc_enable           (osc_en),
    .system_source        (sys_src),
    .slowdown_active      (slow),
    .slowdown_ratio       (ratio),
    .fast_rc_postscale    (post),
    .fast_rc_trim         (trim),
    .pin_map_lock         (pin_lock)
  );

  // ==========================================================
  // compare and report
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // register port master
  task automatic bus(input logic [1:0] a, input logic [15:0] d,
                     input logic w, input logic r);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= w;
    req.rd    <= r;
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic read(input logic [1:0] a, input logic [15:0] m,
                      input logic [15:0] e);
    exp_q.push_back({m, e});
    bus(a, 16'h0000, 1'b0, 1'b1);
    idle(1);
  endtask
  task automatic prot(input logic [15:0] k1, input logic [15:0] k2,
                      input logic [15:0] d);
    bus(CTL, k1, 1'b1, 1'b0);
    bus(CTL, k2, 1'b1, 1'b0);
    bus(CTL, d, 1'b1, 1'b0);
    idle(1);
  endtask
  task automatic lo(input logic [15:0] d);
    prot(16'h0046, 16'h0057, d);
  endtask
  task automatic toggle(input int n);
    repeat (n) begin
      tick <= ~tick;
      repeat (2) @(posedge clk);
    end
  endtask

  // read data watcher: oldest note against the cycle after a read
  always @(posedge clk) begin
    if (rd_d) begin
      note = exp_q.pop_front();
      check(rdata & note[31:16], note[15:0]);
    end
    rd_d <= req.rd;
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [15:0] d;
    int          i;
    void'($urandom(32'hc09d));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    idle(2);
    read(CTL, 16'hffff, 16'h0000);
    read(DIV, 16'hffff, {1'b0, osc_switch_pkg::RST_RATIO, 1'b0,
         osc_switch_pkg::RST_POSTSCALE, 8'h00});
    read(FAST_RC_TRIM, 16'hffff, {10'h000, osc_switch_pkg::RST_TRIM});
    read(2'h3, 16'hffff, 16'h0000);
    repeat (4) begin
      d = 16'($urandom);
      bus(FAST_RC_TRIM, d, 1'b1, 1'b0);
      bus(DIV, d & 16'h77ff, 1'b1, 1'b0);
      idle(1);
      check({10'h0, trim}, {10'h0, d[5:0]});
      check({13'h0, ratio}, {13'h0, d[14:12]});
      check({13'h0, post}, {13'h0, d[10:8]});
      read(FAST_RC_TRIM, 16'hffff, {10'h000, d[5:0]});
      read(DIV, 16'hffff, d & 16'h7700);
    end
    // slowdown dropped by an interrupt
    bus(DIV, 16'h8800, 1'b1, 1'b0);
    idle(2);
    check({15'h0, slow}, 16'h0001);
    irq <= 1'b1;
    @(posedge clk);
    irq <= 1'b0;
    idle(2);
    read(DIV, 16'hffff, 16'h8000);
    check({15'h0, slow}, 16'h0000);
    // bad key, then a full switch to primary
    // plain source to plain source, no pll to pll hop
    prot(16'h7800, 16'h1200, 16'h0300);
    read(CTL, 16'h0700, 16'h0000);
    prot(16'h7800, 16'h9a00, 16'h0200);
    read(CTL, 16'h7700, 16'h0200);
    lo(16'h0003);
    read(CTL, 16'h7703, 16'h0203);
    check({15'h0, osc_en.secondary}, 16'h0001);
    toggle(12);
    check({13'h0, sys_src}, 16'h0000);
    xtal <= 1'b1;
    idle(8);
    check({13'h0, sys_src}, 16'h0000);
    for (i = 0; i < 50 && sys_src !== osc_switch_pkg::SRC_PRIMARY; i++)
      toggle(1);
    if (i == 50) begin
      n_mismatch++;
      conclude();
    end
    read(CTL, 16'h77df, 16'h2202);
    check({11'h0, osc_en}, 16'h001a);
    for (i = 0; i < 2; i++) begin
      lo({13'h0, i[0], 2'h2});
      sleep <= 1'b1;
      idle(3);
      check({15'h0, osc_en.primary}, {15'h0, i[0]});
      sleep <= 1'b0;
      idle(3);
    end
    lo(16'h0007);
    idle(4);
    read(CTL, 16'h7701, 16'h2200);
    // pin map lock under one-shot
    bus(CTL, 16'h0042, 1'b1, 1'b0);
    idle(2);
    check({15'h0, pin_lock}, 16'h0000);
    lo(16'h0042);
    check({15'h0, pin_lock}, 16'h0001);
    lo(16'h0002);
    check({15'h0, pin_lock}, 16'h0001);
    // clock fail flag set by hardware, software may only clear it
    fail <= 1'b1;
    idle(4);
    fail <= 1'b0;
    idle(4);
    read(CTL, 16'h0008, 16'h0008);
    lo(16'h0002);
    read(CTL, 16'h0008, 16'h0000);
    lo(16'h000a);
    read(CTL, 16'h0008, 16'h0000);
    // switching disabled by configuration
    cfg <= 2'h2;
    boot <= 3'h4;
    rstn <= 1'b0;
    idle(2);
    rstn <= 1'b1;
    idle(2);
    read(CTL, 16'h7000, 16'h4000);
    lo(16'h0001);
    read(CTL, 16'h7001, 16'h4000);
    idle(2);
    conclude();
  end
endmodule
